// [pkg/ifd_defs.svh]
// Constants for the instruction format decoder
// Functional notes
// - Table pointer modes: unchanged, post-increment, post-decrement, pre-increment.
// - Relative targets are signed displacements; absolute targets are direct addresses.
// - Fast bit 0 leaves shadows alone; 1 saves or restores them.
// - Table pointer is 21 bits wide; table latch is 8 bits.
// - Don't-care positions never affect decoding; tools fill them with zero.
// - Indexed indirect addressing uses 7-bit source and destination offsets.
// - Byte format: opcode high, dest bit 9, bank bit 8, address 7..0.
// - Bank bit 0 forces access bank; 1 uses bank selector register.
// - File move: 12-bit source in word one, 1111 plus destination in two.
// - Bit format: bit index 11..9, bank bit 8, address 7..0.
// - Literal format: opcode 15..8, immediate 7..0.
// - Absolute jump target: low byte word one, bits 19..8 from word two.
// - Call uses jump layout plus fast bit at bit 8.
// - Long relative branch: opcode 15..11, 11-bit displacement 10..0.
// - Conditional branch: opcode 15..8, 8-bit displacement 7..0.
// - A lone second word, top four bits ones, executes as no-operation.
// - Instruction cycle is four clocks; a taken branch decoded from a single word adds one idle cycle.
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH
`define IFD_PC_W 21
`define IFD_TABLE_PTR_W 21
`define IFD_LATCH_W 8
`define IFD_PHASES 4
`define IFD_SECOND_TAG 4'hF
`define IFD_OP_FILE_MOVE 4'hC
`define IFD_OP_ABS_JUMP 8'hEF
`define IFD_OP_CALL 7'h76
`define IFD_OP_LONG_REL 5'h1A
`define IFD_OP_COND_LO 8'hE2
`define IFD_OP_COND_HI 8'hE6
`define IFD_OP_TBL 12'h000
`define IFD_OP_LIT 5'h01
`define IFD_BIT_NIB_LO 4'h7
`define IFD_BIT_NIB_HI 4'hB
`define IFD_OP_SUBFSR 8'hE9
`define IFD_OP_ADDFSR 8'hE8
`define IFD_ZOFF_W 7
`endif

// [pkg/ifd_pkg.sv]
// Types for the instruction format decoder
package ifd_pkg;
  typedef enum logic [3:0] {
    IFD_TBL_KEEP = 4'h1,
    IFD_TBL_POSTINC = 4'h2,
    IFD_TBL_POSTDEC = 4'h4,
    IFD_TBL_PREINC = 4'h8
  } ifd_tbl_mode_type;
  typedef enum logic [7:0] {
    IFD_FMT_BYTE = 8'h01,
    IFD_FMT_MOVE = 8'h02,
    IFD_FMT_BIT = 8'h04,
    IFD_FMT_LIT = 8'h08,
    IFD_FMT_JUMP = 8'h10,
    IFD_FMT_LONGREL = 8'h20,
    IFD_FMT_CONDREL = 8'h40,
    IFD_FMT_NOP = 8'h80
  } ifd_fmt_type;
  typedef enum logic [2:0] {
    IFD_ST_FIRST = 3'h1,
    IFD_ST_SECOND = 3'h2,
    IFD_ST_FLUSH = 3'h4
  } ifd_state_type;
  typedef struct packed {
    ifd_fmt_type fmt;
    logic [7:0] opcode;
    logic dest_to_file;
    logic use_bank_sel;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [2:0] bit_index;
    logic [7:0] literal;
    logic fast;
    logic [20:0] target;
    logic is_relative;
    logic table_op;
    ifd_tbl_mode_type tbl_mode;
    logic [6:0] zoff_src;
    logic [6:0] zoff_dst;
  } ifd_dec_type;
endpackage

// [hdl/ifd_decoder.sv]
// Instruction format decoder with two-word pairing and cycle pacing
`timescale 1ns/1ps
`default_nettype none
`include "ifd_defs.svh"
module ifd_decoder
  import ifd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fetched word
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  input wire logic [20:0] pc_in,
  // Execute feedback
  input wire logic flow_change,
  // Decoded output
  output logic dec_valid,
  output ifd_dec_type dec_out,
  output logic phase_last,
  output logic word_ready
);
  // Sign-extend an 8-bit or 11-bit displacement and form a word target
  function automatic logic [20:0] rel_target(input logic [20:0] pc,
      input logic [10:0] disp, input logic wide);
    logic [20:0] ext;
    ext = wide ? {{10{disp[10]}}, disp} : {{13{disp[7]}}, disp[7:0]};
    rel_target = pc + 21'h000002 + {ext[19:0], 1'b0};
  endfunction
  ifd_state_type state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [15:0] first_reg, first_next;
  ifd_dec_type dec_reg, dec_next;
  logic valid_reg, valid_next;
  logic step;
  ifd_dec_type d;
  // Phase counter: one instruction cycle is four clocks
  assign step = (phase_reg == 2'(`IFD_PHASES - 1));
  // Next-state and field decode
  always_comb begin
    d = '0;
    d.fmt = IFD_FMT_NOP;
    d.tbl_mode = IFD_TBL_KEEP;
    phase_next = phase_reg + 2'h1;
    state_next = state_reg;
    first_next = first_reg;
    dec_next = dec_reg;
    valid_next = 1'b0;
    if (step) begin
      case (state_reg)
        IFD_ST_FIRST: begin
          if (word_valid) begin
            d.opcode = word_in[15:8];
            d.dest_to_file = word_in[9];
            d.use_bank_sel = word_in[8];
            d.src_addr = {4'h0, word_in[7:0]};
            d.bit_index = word_in[11:9];
            d.literal = word_in[7:0];
            if (word_in[15:4] == `IFD_OP_TBL && word_in[3]) begin
              d.table_op = 1'b1;
              d.fmt = IFD_FMT_LIT;
              case (word_in[1:0])
                2'h0: d.tbl_mode = IFD_TBL_KEEP;
                2'h1: d.tbl_mode = IFD_TBL_POSTINC;
                2'h2: d.tbl_mode = IFD_TBL_POSTDEC;
                default: d.tbl_mode = IFD_TBL_PREINC;
              endcase
              valid_next = 1'b1;
            end else if (word_in[15:12] == `IFD_SECOND_TAG) begin
              d.fmt = IFD_FMT_NOP;
              valid_next = 1'b1;
            end else if (word_in[15:12] == `IFD_OP_FILE_MOVE) begin
              d.fmt = IFD_FMT_MOVE;
              d.src_addr = word_in[11:0];
              first_next = word_in;
              state_next = IFD_ST_SECOND;
            end else if (word_in[15:8] == `IFD_OP_ABS_JUMP
                || word_in[15:9] == `IFD_OP_CALL) begin
              first_next = word_in;
              state_next = IFD_ST_SECOND;
            end else if (word_in[15:11] == `IFD_OP_LONG_REL) begin
              d.fmt = IFD_FMT_LONGREL;
              d.is_relative = 1'b1;
              d.target = rel_target(pc_in, word_in[10:0], 1'b1);
              valid_next = 1'b1;
            end else if (word_in[15:8] >= `IFD_OP_COND_LO
                && word_in[15:8] <= `IFD_OP_COND_HI) begin
              d.fmt = IFD_FMT_CONDREL;
              d.is_relative = 1'b1;
              d.target = rel_target(pc_in, {3'h0, word_in[7:0]}, 1'b0);
              valid_next = 1'b1;
            end else if (word_in[15:8] == `IFD_OP_ADDFSR
                || word_in[15:8] == `IFD_OP_SUBFSR) begin
              d.fmt = IFD_FMT_LIT;
              d.zoff_src = word_in[6:0];
              valid_next = 1'b1;
            end else if (word_in[15:11] == `IFD_OP_LIT) begin
              d.fmt = IFD_FMT_LIT;
              valid_next = 1'b1;
            end else if (word_in[15:12] >= `IFD_BIT_NIB_LO
                && word_in[15:12] <= `IFD_BIT_NIB_HI) begin
              d.fmt = IFD_FMT_BIT;
              valid_next = 1'b1;
            end else if (word_in[15:12] == 4'hE || word_in[15:12] == 4'hD) begin
              d.fmt = IFD_FMT_JUMP;
              d.fast = word_in[0];
              valid_next = 1'b1;
            end else begin
              d.fmt = IFD_FMT_BYTE;
              valid_next = 1'b1;
            end
            if (valid_next) begin
              dec_next = d;
              if (flow_change)
                state_next = IFD_ST_FLUSH;
            end
          end
        end
        IFD_ST_SECOND: begin
          if (word_valid) begin
            d = '0;
            d.tbl_mode = IFD_TBL_KEEP;
            d.opcode = first_reg[15:8];
            if (word_in[15:12] != `IFD_SECOND_TAG) begin
              d.fmt = IFD_FMT_NOP;
            end else if (first_reg[15:12] == `IFD_OP_FILE_MOVE) begin
              d.fmt = IFD_FMT_MOVE;
              d.src_addr = first_reg[11:0];
              d.dst_addr = word_in[11:0];
              d.zoff_src = first_reg[6:0];
              d.zoff_dst = word_in[6:0];
            end else begin
              d.fmt = IFD_FMT_JUMP;
              d.target = {1'b0, word_in[11:0], first_reg[7:0]};
              if (first_reg[15:9] == `IFD_OP_CALL)
                d.fast = first_reg[8];
            end
            dec_next = d;
            valid_next = 1'b1;
            state_next = IFD_ST_FIRST;
          end
        end
        IFD_ST_FLUSH: begin
          state_next = IFD_ST_FIRST;
        end
        default: begin
          state_next = IFD_ST_FIRST;
        end
      endcase
    end
  end
  // Register all decoder state; don't-care bits reach only the field copies above
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= IFD_ST_FIRST;
      phase_reg <= 2'h0;
      first_reg <= 16'h0000;
      dec_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      first_reg <= first_next;
      dec_reg <= dec_next;
      valid_reg <= valid_next;
    end
  end
  // Output flops
  logic last_reg, ready_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      last_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      last_reg <= (phase_next == 2'(`IFD_PHASES - 1));
      ready_reg <= (phase_next == 2'(`IFD_PHASES - 1))
        && (state_next != IFD_ST_FLUSH);
    end
  end
  assign dec_valid = valid_reg;
  assign dec_out = dec_reg;
  assign phase_last = last_reg;
  assign word_ready = ready_reg;
endmodule // ifd_decoder
`default_nettype wire

// [tb/ifd_chk.sv]
// Assertions on the decoder outputs
`timescale 1ns/1ps
`default_nettype none
module ifd_chk
  import ifd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  input wire logic [20:0] pc_in,
  input wire logic flow_change,
  input wire logic dec_valid,
  input wire ifd_dec_type dec_out,
  input wire logic phase_last,
  input wire logic word_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Three quiet clocks, then the last phase again
  sequence idle_then_last;
    !phase_last [*3] ##1 phase_last;
  endsequence
  a_phase_period: assert property (phase_last |=> idle_then_last)
    else $error("phase period wrong");
  a_valid_pulse: assert property (dec_valid |=> !dec_valid)
    else $error("decode pulse too long");
  a_take_edge: assert property (dec_valid |-> $past(phase_last))
    else $error("decode off the last phase");
  a_byte_dest: assert property (dec_valid && dec_out.fmt == IFD_FMT_BYTE
    |-> dec_out.dest_to_file == $past(word_in[9])) else $error("dest bit");
  a_bank_bit: assert property (dec_valid && dec_out.fmt inside
    {IFD_FMT_BYTE, IFD_FMT_BIT} |-> dec_out.use_bank_sel == $past(word_in[8]))
    else $error("bank bit");
  a_bit_index: assert property (dec_valid && dec_out.fmt == IFD_FMT_BIT
    |-> dec_out.bit_index == $past(word_in[11:9])) else $error("bit index");
  a_lit_value: assert property (dec_valid && dec_out.fmt == IFD_FMT_LIT
    |-> dec_out.literal == $past(word_in[7:0])) else $error("literal");
  a_jump_high: assert property (dec_valid && dec_out.fmt == IFD_FMT_JUMP
    && $past(word_in[15:12]) == 4'hF
    |-> dec_out.target[20:8] == {1'b0, $past(word_in[11:0])})
    else $error("jump target");
  a_move_dst: assert property (dec_valid && dec_out.fmt == IFD_FMT_MOVE
    |-> dec_out.dst_addr == $past(word_in[11:0])) else $error("move dest");
  a_cond_target: assert property (dec_valid && dec_out.fmt == IFD_FMT_CONDREL
    |-> dec_out.target == $past(pc_in) + 21'h2 +
    {{12{$past(word_in[7])}}, $past(word_in[7:0]), 1'b0}) else $error("rel");
endmodule // ifd_chk
`default_nettype wire

// [tb/ifd_fetch.sv]
// Fetch model handing words to the decoder in program order
`timescale 1ns/1ps
`default_nettype none
module ifd_fetch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Word handshake
  input wire logic word_ready,
  output logic word_valid,
  output logic [15:0] word_in,
  output logic [20:0] pc_in
);
  logic [15:0] mem [0:15];
  // Step one word on each take, word held until then
  always_ff @(posedge clk) begin
    if (reset) pc_in <= 21'h0;
    else if (word_ready) pc_in <= pc_in + 21'h2;
  end
  // Ready to offer the word at the counter whenever out of reset
  assign word_valid = !reset;
  assign word_in = mem[pc_in[4:1]];
endmodule // ifd_fetch
`default_nettype wire

// [tb/tb.sv]
// Testbench for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ifd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic flow_change = 1'b0;
  logic word_valid, dec_valid, phase_last, word_ready;
  logic [15:0] word_in;
  logic [20:0] pc_in;
  ifd_dec_type dec_out;
  int bad_count = 0;
  int total_checks = 0;
  int wait_n = 0;
  // 40 ns clock
  always #20 clk = ~clk;
  ifd_fetch i_ifd_fetch (.clk(clk), .reset(reset), .word_ready(word_ready),
    .word_valid(word_valid), .word_in(word_in), .pc_in(pc_in));
  ifd_decoder i_ifd_decoder (.clk(clk), .reset(reset), .word_in(word_in),
    .word_valid(word_valid), .pc_in(pc_in), .flow_change(flow_change),
    .dec_valid(dec_valid), .dec_out(dec_out), .phase_last(phase_last),
    .word_ready(word_ready));
  task chk(input logic [20:0] g, input logic [20:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for the next decode pulse
  task wait_dec;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (dec_valid !== 1'b1 && n < 40);
    wait_n = n;
    if (dec_valid !== 1'b1) begin
      bad_count++;
      final_report;
    end
  endtask
  task byte_case;
    wait_dec;
    chk(21'(dec_out.fmt), 21'(IFD_FMT_BYTE));
    chk(21'(dec_out.dest_to_file), 21'h1);
    chk(21'(dec_out.use_bank_sel), 21'h0);
    wait_dec;
    chk(21'(dec_out.dest_to_file), 21'h0);
    chk(21'(dec_out.use_bank_sel), 21'h1);
  endtask
  task bit_lit_case;
    wait_dec;
    chk(21'(dec_out.bit_index), 21'h5);
    wait_dec;
    chk(21'(dec_out.fmt), 21'(IFD_FMT_LIT));
    chk(21'(dec_out.literal), 21'h7F);
  endtask
  task jump_case;
    wait_dec;
    chk(dec_out.target, 21'h56734);
    wait_dec;
    chk(dec_out.target, 21'h0AB12);
    chk(21'(dec_out.fast), 21'h1);
  endtask
  task move_case;
    wait_dec;
    chk(21'(dec_out.src_addr), 21'h123);
    chk(21'(dec_out.dst_addr), 21'h456);
    wait_dec;
    chk(21'(dec_out.fmt), 21'(IFD_FMT_NOP));
  endtask
  task rel_case;
    wait_dec;
    chk(dec_out.target, 21'h14);
    wait_dec;
    chk(dec_out.target, 21'h20);
    wait_dec;
    chk(dec_out.target, 21'h1FFFFC);
  endtask
  // Table op taken with flow change, then one refused instruction cycle
  task flush_case;
    @(posedge clk);
    flow_change <= 1'b1;
    wait_dec;
    chk(21'(dec_out.tbl_mode), 21'(IFD_TBL_POSTINC));
    chk(21'(dec_out.table_op), 21'h1);
    @(posedge clk);
    flow_change <= 1'b0;
    wait_dec;
    chk(21'(wait_n), 21'h7);
    chk(21'(dec_out.literal), 21'h05);
  endtask
  initial begin
    // Program image, unused slots zero-filled lone second words
    for (int i = 0; i < 16; i++) i_ifd_fetch.mem[i] = 16'hF000;
    i_ifd_fetch.mem[0] = 16'h265A;
    i_ifd_fetch.mem[1] = 16'h2555;
    i_ifd_fetch.mem[2] = 16'h8B12;
    i_ifd_fetch.mem[3] = 16'h0E7F;
    i_ifd_fetch.mem[4] = 16'hEF34;
    i_ifd_fetch.mem[5] = 16'hF567;
    i_ifd_fetch.mem[6] = 16'hED12;
    i_ifd_fetch.mem[7] = 16'hF0AB;
    i_ifd_fetch.mem[8] = 16'hC123;
    i_ifd_fetch.mem[9] = 16'hF456;
    i_ifd_fetch.mem[11] = 16'hD7FE;
    i_ifd_fetch.mem[12] = 16'hE203;
    i_ifd_fetch.mem[13] = 16'hE2F0;
    i_ifd_fetch.mem[14] = 16'h0009;
    i_ifd_fetch.mem[15] = 16'h0F05;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    byte_case;
    bit_lit_case;
    jump_case;
    move_case;
    rel_case;
    flush_case;
    final_report;
  end
endmodule // tb
bind ifd_decoder ifd_chk i_ifd_chk (.clk(clk), .reset(reset),
  .word_valid(word_valid), .word_in(word_in), .pc_in(pc_in),
  .flow_change(flow_change), .dec_valid(dec_valid), .dec_out(dec_out),
  .phase_last(phase_last), .word_ready(word_ready));
`default_nettype wire
